//--- pts_defs.vh
// Offsets, field positions, reset values and constants of the timestamp block
`ifndef PTS_DEFS_VH
`define PTS_DEFS_VH
`define PTS_ADR_CTRL      8'h00
`define PTS_ADR_IRQ_STAT  8'h04
`define PTS_ADR_IRQ_MASK  8'h08
`define PTS_ADR_STATE     8'h0C
`define PTS_CTRL_RST      2'h3
`define PTS_CTRL_TS_EN    0
`define PTS_CTRL_RX_EN    1
`define PTS_IRQ_W         4
`define PTS_IRQ_TX_TS     0
`define PTS_IRQ_RX_TS     1
`define PTS_IRQ_WR_ERR    2
`define PTS_IRQ_RD_ERR    3
`define PTS_IRQ_MASK_RST  4'h0
`define PTS_OP_NONE       2'h0
`define PTS_OP_ONE_STEP   2'h1
`define PTS_OP_TWO_STEP   2'h2
`define PTS_OP_RSVD       2'h3
`define PTS_TIME_W        80
`define PTS_TAG_W         16
`define PTS_TRIM_W        11
`define PTS_NS_PER_SEC    33'h03B9ACA00
`define PTS_TC_SIGN_BIT   63
`define PTS_TRIM_FRAC_SH  13
`endif

//--- pts_tag_fifo.v
// Flip-flop FIFO holding tag, opcode and capture time of stamped frames
module pts_tag_fifo
#(
    parameter DW = 98,
    parameter AW = 2
)
(
    input  wire          clk_i,
    input  wire          rst_i,
    input  wire          ce_i,
    input  wire          push_i,
    input  wire [DW-1:0] din_i,
    input  wire          pop_i,
    output wire [DW-1:0] dout_o,
    output wire          full_o,
    output wire          empty_o,
    output wire [AW:0]   level_o
);
    localparam DEPTH = 1 << AW;

    reg [DW-1:0] mem_reg [0:DEPTH-1];
    reg [AW-1:0] wr_ptr_reg;
    reg [AW-1:0] rd_ptr_reg;
    reg [AW:0]   cnt_reg;
    wire         do_push;
    wire         do_pop;

    // Refused operations leave the storage untouched
    assign full_o  = (cnt_reg == DEPTH[AW:0]);
    assign empty_o = (cnt_reg == {(AW+1){1'b0}});
    assign do_push = push_i & ~full_o;
    assign do_pop  = pop_i & ~empty_o;
    assign dout_o  = mem_reg[rd_ptr_reg];
    assign level_o = cnt_reg;

    // Storage written by index, no reset needed on data
    always @(posedge clk_i)
    begin
        if (ce_i && do_push)
        begin
            mem_reg[wr_ptr_reg] <= din_i;
        end
    end

    // Pointers and fill count
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            wr_ptr_reg <= {AW{1'b0}};
            rd_ptr_reg <= {AW{1'b0}};
            cnt_reg    <= {(AW+1){1'b0}};
        end
        else if (ce_i)
        begin
            if (do_push)
            begin
                wr_ptr_reg <= wr_ptr_reg + 1'b1;
            end
            if (do_pop)
            begin
                rd_ptr_reg <= rd_ptr_reg + 1'b1;
            end
            if (do_push && !do_pop)
            begin
                cnt_reg <= cnt_reg + 1'b1;
            end
            else if (do_pop && !do_push)
            begin
                cnt_reg <= cnt_reg - 1'b1;
            end
        end
    end
endmodule

//--- pts_ctrl.v
// Timestamp control for the transmit and receive paths with register slave
`include "pts_defs.vh"

// Overview of operation
// - Stamping active only with build option; registers always answer
// - Normal mode: seconds 48 bits, nanoseconds 32
// - Transparent mode: bit63 zero, ns, fraction
// - One-step enable inserts time into frames
// - Trim offsets one-step time, 8.3 ns format
// - Transparent select makes time a correction
// - Transparent mode adds only trim to the correction
// - Correction sign bit forced to zero
// - Flag set on tag FIFO write failure
// - Flag set on tag FIFO read failure
// - Error flags cleared only by path reset or system reset
// - Transmit timestamp output in timer format
// - Receive timestamp valid with start of packet
// - Client tag returned with frame timestamp
module pts_ctrl
#(
    parameter TS_BUILD_OPTION = 1,
    parameter FIFO_AW         = 2
)
(
    input  wire        CORE_CLK_I,
    input  wire        SRST_I,
    input  wire        CE_I,
    input  wire        WB_CYC_I,
    input  wire        WB_STB_I,
    input  wire        WB_WE_I,
    input  wire [7:0]  WB_ADR_I,
    input  wire [3:0]  WB_SEL_I,
    input  wire [31:0] WB_DAT_I,
    output wire [31:0] WB_DAT_O,
    output wire        WB_ACK_O,
    output wire        IRQ_O,
    input  wire        TX_PATH_RST_I,
    input  wire [79:0] TX_SYSTIME_I,
    input  wire        TX_SOP_I,
    input  wire [1:0]  TX_FRAME_TS_OPCODE_I,
    input  wire [15:0] TX_TAG_I,
    input  wire        TX_ONE_STEP_EN_I,
    input  wire [10:0] TX_LAT_TRIM_I,
    input  wire        TRANSP_CLK_MODE_I,
    input  wire        TX_TS_DONE_I,
    output wire        TX_INS_VALID_O,
    output wire [79:0] TX_INS_TS_O,
    output wire        TX_TS_VALID_O,
    output wire [15:0] TX_TS_TAG_O,
    output wire [79:0] TX_TS_O,
    output wire        TX_FIFO_WR_ERR_O,
    output wire        TX_FIFO_RD_ERR_O,
    input  wire [79:0] RX_SYSTIME_I,
    input  wire        RX_SOP_I,
    output wire        RX_TS_VALID_O,
    output wire [79:0] RX_TS_O
);
    localparam FW = `PTS_TAG_W + 2 + `PTS_TIME_W;

    reg  [1:0]              ctrl_reg;
    reg  [`PTS_IRQ_W-1:0]   irq_stat_reg;
    reg  [`PTS_IRQ_W-1:0]   irq_stat_next;
    reg  [`PTS_IRQ_W-1:0]   irq_mask_reg;
    reg                     ack_reg;
    reg  [31:0]             dat_reg;
    reg  [31:0]             dat_next;
    reg                     wr_err_reg;
    reg                     rd_err_reg;
    reg                     ins_valid_reg;
    reg  [79:0]             ins_ts_reg;
    reg                     ts_valid_reg;
    reg  [15:0]             ts_tag_reg;
    reg  [79:0]             ts_reg;
    reg  [79:0]             rx_time_reg;
    wire                    ts_on;
    wire                    stamp_op;
    wire                    push;
    wire                    pop;
    wire                    fifo_full;
    wire                    fifo_empty;
    wire [FIFO_AW:0]        fifo_level;
    wire [FW-1:0]           fifo_dout;
    wire [79:0]             tx_time;
    wire                    wb_req;
    wire                    wb_wr;
    wire [`PTS_IRQ_W-1:0]   events;

    // Clears the correction sign bit in transparent mode
    function [79:0] pts_sign_fix;
        input [79:0] t;
        input        tc;
        begin
            pts_sign_fix = t;
            if (tc)
            begin
                pts_sign_fix[`PTS_TC_SIGN_BIT] = 1'b0;
            end
        end
    endfunction

    // Adds the latency trim in whichever time format is active
    function [79:0] pts_trim_add;
        input [79:0] t;
        input [10:0] trim;
        input        tc;
        reg   [62:0] sum;
        reg   [32:0] ns;
        begin
            sum = 63'h0;
            ns  = 33'h0;
            pts_trim_add = t;
            if (tc)
            begin
                // Fraction is 16 bits, trim fraction only 3 of them
                sum = t[62:0] + ({52'h0, trim} << `PTS_TRIM_FRAC_SH);
                pts_trim_add = {t[79:64], 1'b0, sum};
            end
            else
            begin
                // Whole ns only; trim fraction has no place here
                ns = {1'b0, t[31:0]} + {25'h0, trim[10:3]};
                if (ns >= `PTS_NS_PER_SEC)
                begin
                    ns = ns - `PTS_NS_PER_SEC;
                    pts_trim_add[79:32] = t[79:32] + 48'h1;
                end
                pts_trim_add[31:0] = ns[31:0];
            end
        end
    endfunction

    // Stamping disabled when built without timestamping or with the enable bit clear; registers still answer
    assign ts_on    = (TS_BUILD_OPTION != 0) & ctrl_reg[`PTS_CTRL_TS_EN];
    assign stamp_op = (TX_FRAME_TS_OPCODE_I == `PTS_OP_ONE_STEP) |
                      (TX_FRAME_TS_OPCODE_I == `PTS_OP_TWO_STEP);
    assign push     = ts_on & TX_SOP_I & stamp_op;
    assign pop      = ts_on & TX_TS_DONE_I;
    assign tx_time  = pts_sign_fix(TX_SYSTIME_I, TRANSP_CLK_MODE_I);

    // Tag FIFO pairs each stamped frame with its tag
    pts_tag_fifo
    #(
        .DW (FW),
        .AW (FIFO_AW)
    )
    u_tag_fifo
    (
        .clk_i   (CORE_CLK_I),
        .rst_i   (SRST_I | TX_PATH_RST_I),
        .ce_i    (CE_I),
        .push_i  (push),
        .din_i   ({TX_TAG_I, TX_FRAME_TS_OPCODE_I, tx_time}),
        .pop_i   (pop),
        .dout_o  (fifo_dout),
        .full_o  (fifo_full),
        .empty_o (fifo_empty),
        .level_o (fifo_level)
    );

    // Transmit capture, insertion and two-step return
    always @(posedge CORE_CLK_I)
    begin
        if (SRST_I || TX_PATH_RST_I)
        begin
            ins_valid_reg <= 1'b0;
            ins_ts_reg    <= 80'h0;
            ts_valid_reg  <= 1'b0;
            ts_tag_reg    <= 16'h0;
            ts_reg        <= 80'h0;
        end
        else if (CE_I)
        begin
            // Insertion time sampled at start of packet
            ins_valid_reg <= push & TX_ONE_STEP_EN_I &
                (TX_FRAME_TS_OPCODE_I == `PTS_OP_ONE_STEP);
            if (push)
            begin
                ins_ts_reg <= pts_trim_add(tx_time, TX_LAT_TRIM_I,
                                           TRANSP_CLK_MODE_I);
            end
            // Two-step time is untrimmed; trim is relative to it
            ts_valid_reg <= pop & ~fifo_empty;
            if (pop && !fifo_empty)
            begin
                ts_tag_reg <= fifo_dout[FW-1:FW-16];
                ts_reg     <= fifo_dout[79:0];
            end
        end
    end

    // Error flags stick until the transmit path is reset
    always @(posedge CORE_CLK_I)
    begin
        if (SRST_I || TX_PATH_RST_I)
        begin
            wr_err_reg <= 1'b0;
            rd_err_reg <= 1'b0;
        end
        else if (CE_I)
        begin
            if (push && fifo_full)
            begin
                wr_err_reg <= 1'b1;
            end
            if (pop && fifo_empty)
            begin
                rd_err_reg <= 1'b1;
            end
        end
    end

    // Receive time pipelined one stage ahead of the capture plane
    always @(posedge CORE_CLK_I)
    begin
        if (SRST_I)
        begin
            rx_time_reg <= 80'h0;
        end
        else if (CE_I)
        begin
            rx_time_reg <= pts_sign_fix(RX_SYSTIME_I, TRANSP_CLK_MODE_I);
        end
    end

    assign TX_INS_VALID_O   = ins_valid_reg;
    assign TX_INS_TS_O      = ins_ts_reg;
    assign TX_TS_VALID_O    = ts_valid_reg;
    assign TX_TS_TAG_O      = ts_tag_reg;
    assign TX_TS_O          = ts_reg;
    assign TX_FIFO_WR_ERR_O = wr_err_reg;
    assign TX_FIFO_RD_ERR_O = rd_err_reg;
    // Valid follows the packet start within the same cycle
    assign RX_TS_VALID_O    = ts_on & ctrl_reg[`PTS_CTRL_RX_EN] &
                              RX_SOP_I;
    assign RX_TS_O          = rx_time_reg;

    // Events feeding the sticky status bits
    assign events = {pop & fifo_empty, push & fifo_full,
                     RX_TS_VALID_O, pop & ~fifo_empty};

    // Bus request decode; ack answers one cycle after the strobe
    assign wb_req = WB_CYC_I & WB_STB_I & ~ack_reg;
    assign wb_wr  = wb_req & WB_WE_I & WB_SEL_I[0];

    // Set wins over a write-one clear in the same cycle
    always @*
    begin
        irq_stat_next = irq_stat_reg;
        if (wb_wr && WB_ADR_I == `PTS_ADR_IRQ_STAT)
        begin
            irq_stat_next = irq_stat_reg & ~WB_DAT_I[`PTS_IRQ_W-1:0];
        end
        irq_stat_next = irq_stat_next | events;
    end

    // Read data mux; unmapped addresses read zero
    always @*
    begin
        dat_next = 32'h0;
        case (WB_ADR_I)
            `PTS_ADR_CTRL:     dat_next[1:0] = ctrl_reg;
            `PTS_ADR_IRQ_STAT: dat_next[3:0] = irq_stat_reg;
            `PTS_ADR_IRQ_MASK: dat_next[3:0] = irq_mask_reg;
            `PTS_ADR_STATE:
            begin
                dat_next[0]            = wr_err_reg;
                dat_next[1]            = rd_err_reg;
                dat_next[2]            = fifo_empty;
                dat_next[3]            = fifo_full;
                dat_next[8+FIFO_AW:8]  = fifo_level;
            end
            default:           dat_next = 32'h0;
        endcase
    end

    // Register file and bus handshake
    always @(posedge CORE_CLK_I)
    begin
        if (SRST_I)
        begin
            ctrl_reg     <= `PTS_CTRL_RST;
            irq_stat_reg <= {`PTS_IRQ_W{1'b0}};
            irq_mask_reg <= `PTS_IRQ_MASK_RST;
            ack_reg      <= 1'b0;
            dat_reg      <= 32'h0;
        end
        else if (CE_I)
        begin
            ack_reg      <= wb_req;
            irq_stat_reg <= irq_stat_next;
            if (wb_req && !WB_WE_I)
            begin
                dat_reg <= dat_next;
            end
            if (wb_wr && WB_ADR_I == `PTS_ADR_CTRL)
            begin
                ctrl_reg <= WB_DAT_I[1:0];
            end
            if (wb_wr && WB_ADR_I == `PTS_ADR_IRQ_MASK)
            begin
                irq_mask_reg <= WB_DAT_I[`PTS_IRQ_W-1:0];
            end
        end
    end

    assign WB_ACK_O = ack_reg;
    assign WB_DAT_O = dat_reg;
    // Level interrupt while any unmasked status bit stands
    assign IRQ_O    = |(irq_stat_reg & irq_mask_reg);
endmodule

//--- pts_ctrl_assertions.sv
// Port-level timing checks for the timestamp control block
module pts_ctrl_assertions
(
    input wire        CORE_CLK_I,
    input wire        SRST_I,
    input wire        CE_I,
    input wire        WB_CYC_I,
    input wire        WB_STB_I,
    input wire        WB_ACK_O,
    input wire        TX_PATH_RST_I,
    input wire        TX_SOP_I,
    input wire [1:0]  TX_FRAME_TS_OPCODE_I,
    input wire        TX_ONE_STEP_EN_I,
    input wire        TRANSP_CLK_MODE_I,
    input wire        TX_TS_DONE_I,
    input wire        TX_INS_VALID_O,
    input wire        TX_TS_VALID_O,
    input wire        TX_FIFO_WR_ERR_O,
    input wire        TX_FIFO_RD_ERR_O,
    input wire [79:0] RX_SYSTIME_I,
    input wire        RX_SOP_I,
    input wire        RX_TS_VALID_O,
    input wire [79:0] RX_TS_O
);
    default clocking @(posedge CORE_CLK_I);
    endclocking
    default disable iff (SRST_I);
    // Bus request not yet answered
    sequence bus_req;
        WB_CYC_I && WB_STB_I && !WB_ACK_O && CE_I;
    endsequence
    // Frame asking for in-line insertion
    sequence one_step_req;
        TX_SOP_I && CE_I && !TX_PATH_RST_I && TX_ONE_STEP_EN_I
            && TX_FRAME_TS_OPCODE_I == 2'h1;
    endsequence
    bus_ack_a:
        assert property (bus_req |=> WB_ACK_O)
        else $error("no ack after request");
    ack_pulse_a:
        assert property (WB_ACK_O && CE_I |=> !WB_ACK_O)
        else $error("ack longer than one cycle");
    rx_valid_a:
        assert property (RX_TS_VALID_O |-> RX_SOP_I)
        else $error("rx valid without start");
    // Sign bit dropped only in transparent mode
    rx_time_a:
        assert property ($past(CE_I) && !$past(SRST_I) |-> RX_TS_O ==
            ($past(RX_SYSTIME_I) & ~({79'h0, $past(TRANSP_CLK_MODE_I)} << 63)))
        else $error("rx stamp not previous time");
    one_step_a:
        assert property (one_step_req |=> TX_INS_VALID_O)
        else $error("one-step insert missing");
    ins_cause_a:
        assert property (TX_INS_VALID_O |-> $past(TX_SOP_I)
            && $past(TX_FRAME_TS_OPCODE_I) == 2'h1)
        else $error("insert without one-step frame");
    ts_cause_a:
        assert property (TX_TS_VALID_O |-> $past(TX_TS_DONE_I))
        else $error("return without done");
    wr_sticky_a:
        assert property (TX_FIFO_WR_ERR_O && !TX_PATH_RST_I |=> TX_FIFO_WR_ERR_O)
        else $error("write error dropped");
    rd_sticky_a:
        assert property (TX_FIFO_RD_ERR_O && !TX_PATH_RST_I |=> TX_FIFO_RD_ERR_O)
        else $error("read error dropped");
    err_clear_a:
        assert property (TX_PATH_RST_I && CE_I
            |=> !TX_FIFO_WR_ERR_O && !TX_FIFO_RD_ERR_O)
        else $error("errors kept over path reset");
endmodule

//--- pts_timer_model.sv
// System timer stand-in: 100 ns per cycle, seconds roll at 1e9 ns
module pts_timer_model
#(
    parameter logic [79:0] START = 80'h0
)
(
    input  wire logic        clk_i,
    input  wire logic        ld_i,
    input  wire logic [79:0] val_i,
    output logic      [79:0] time_o
);
    timeunit 1ns;
    timeprecision 1ns;
    initial time_o = START;
    // Stepped on the sampling clock so the block never sees a torn value
    always @(posedge clk_i)
        if (ld_i)
            time_o <= val_i;
        else if (time_o[31:0] >= 32'h3B9AC99C)
            time_o <= {time_o[79:32] + 48'h1, time_o[31:0] - 32'h3B9AC99C};
        else
            time_o <= time_o + 80'h64;
endmodule

//--- pts_ctrl_bench.sv
// Self-checking bench for the timestamp control block
module pts_ctrl_bench;
    timeunit 1ns;
    timeprecision 1ns;
    logic        CORE_CLK_I = 1'b0, SRST_I = 1'b1, CE_I = 1'b1;
    logic        WB_CYC_I = 1'b0, WB_STB_I = 1'b0, WB_WE_I = 1'b0;
    logic [7:0]  WB_ADR_I = 8'h00;
    logic [3:0]  WB_SEL_I = 4'hF;
    logic [31:0] WB_DAT_I = 32'h0, WB_DAT_O, q;
    logic        WB_ACK_O, IRQ_O, TX_PATH_RST_I = 1'b0, TX_SOP_I = 1'b0;
    logic [1:0]  TX_FRAME_TS_OPCODE_I = 2'h0;
    logic [15:0] TX_TAG_I = 16'h0, TX_TS_TAG_O;
    logic        TX_ONE_STEP_EN_I = 1'b1, TRANSP_CLK_MODE_I = 1'b0;
    logic        TX_TS_DONE_I = 1'b0, TX_INS_VALID_O, TX_TS_VALID_O;
    logic [10:0] TX_LAT_TRIM_I = 11'h0A5;
    logic [79:0] TX_SYSTIME_I, RX_SYSTIME_I, TX_INS_TS_O, TX_TS_O, RX_TS_O;
    logic [79:0] tval = 80'h0, t0, t1;
    logic        tld = 1'b0, RX_SOP_I = 1'b0, RX_TS_VALID_O;
    logic        TX_FIFO_WR_ERR_O, TX_FIFO_RD_ERR_O;
    int          errors = 0, total_checks = 0;
    // Depth two so the full case is cheap to reach
    pts_ctrl #(.FIFO_AW(1)) i_dut (.*);
    pts_timer_model i_txt (.clk_i(CORE_CLK_I), .ld_i(tld), .val_i(tval),
        .time_o(TX_SYSTIME_I));
    // Sign bit set so the transparent clearing shows
    pts_timer_model #(.START(80'h0000_8000_0000_0007_0000)) i_rxt
        (.clk_i(CORE_CLK_I), .ld_i(1'b0), .val_i(80'h0), .time_o(RX_SYSTIME_I));
    always #50 CORE_CLK_I = ~CORE_CLK_I;
    task results;
        if (errors == 0 && total_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task chk(input logic [79:0] got, input logic [79:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            errors++;
            $display("wrong value at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    // Classic cycle: hold until ack sampled, then release
    task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge CORE_CLK_I);
        WB_CYC_I <= 1'b1;
        WB_STB_I <= 1'b1;
        WB_WE_I <= w;
        WB_ADR_I <= a;
        WB_DAT_I <= d;
        // Only the watchdog ends a wait for the answer
        while (WB_ACK_O !== 1'b1)
            @(posedge CORE_CLK_I);
        q = WB_DAT_O;
        WB_CYC_I <= 1'b0;
        WB_STB_I <= 1'b0;
    endtask
    // One frame start; time seen by the block is latched in t0
    task sop(input logic [1:0] op, input logic [15:0] tag);
        @(posedge CORE_CLK_I);
        TX_SOP_I <= 1'b1;
        TX_FRAME_TS_OPCODE_I <= op;
        TX_TAG_I <= tag;
        #1 t0 = TX_SYSTIME_I;
        @(posedge CORE_CLK_I);
        TX_SOP_I <= 1'b0;
        #1 chk(TX_INS_VALID_O, op == 2'h1 && TX_ONE_STEP_EN_I);
    endtask
    task pop;
        @(posedge CORE_CLK_I);
        TX_TS_DONE_I <= 1'b1;
        @(posedge CORE_CLK_I);
        TX_TS_DONE_I <= 1'b0;
        #1;
    endtask
    task done(input logic [15:0] tag, input logic [79:0] t);
        pop;
        chk(TX_TS_VALID_O, 1'b1);
        chk(TX_TS_TAG_O, tag);
        chk(TX_TS_O, t);
    endtask
    task t_reg;
        wb(1'b0, 8'h00, 32'h0);
        chk(q, 32'h3);
        wb(1'b0, 8'h08, 32'h0);
        chk(q, 32'h0);
        wb(1'b1, 8'h40, 32'hFFFF);
        wb(1'b0, 8'h40, 32'h0);
        chk(q, 32'h0);
    endtask
    // Stamp is judged while valid stands: time taken at the start edge
    task t_rx;
        @(posedge CORE_CLK_I);
        #1 t0 = RX_SYSTIME_I;
        @(posedge CORE_CLK_I);
        RX_SOP_I <= 1'b1;
        #1 chk(RX_TS_VALID_O, 1'b1);
        chk(RX_TS_O, t0);
        @(posedge CORE_CLK_I);
        RX_SOP_I <= 1'b0;
    endtask
    // Trim of 20 ns pushes 999999990 ns over the second
    task t_one;
        @(posedge CORE_CLK_I);
        tld <= 1'b1;
        tval <= {48'h5, 32'h3B9AC992};
        @(posedge CORE_CLK_I);
        tld <= 1'b0;
        sop(2'h1, 16'hA1);
        chk(TX_INS_TS_O, {t0[79:32] + 48'h1, t0[31:0] - 32'h3B9AC9EC});
        t1 = t0;
        sop(2'h0, 16'hB0);
        sop(2'h3, 16'hB3);
        sop(2'h2, 16'hC2);
        done(16'hA1, t1);
        done(16'hC2, t0);
        wb(1'b1, 8'h08, 32'h1);
        chk(IRQ_O, 1'b1);
        wb(1'b1, 8'h04, 32'h1);
        chk(IRQ_O, 1'b0);
    endtask
    task t_err;
        pop;
        chk(TX_FIFO_RD_ERR_O, 1'b1);
        sop(2'h2, 16'h1);
        sop(2'h2, 16'h2);
        chk(TX_FIFO_WR_ERR_O, 1'b0);
        sop(2'h2, 16'h3);
        chk(TX_FIFO_WR_ERR_O, 1'b1);
        wb(1'b1, 8'h04, 32'hF);
        wb(1'b0, 8'h0C, 32'h0);
        chk(q[9:0], 10'h20B);
        @(posedge CORE_CLK_I);
        TX_PATH_RST_I <= 1'b1;
        @(posedge CORE_CLK_I);
        TX_PATH_RST_I <= 1'b0;
        #1 chk({TX_FIFO_WR_ERR_O, TX_FIFO_RD_ERR_O}, 2'h0);
    endtask
    // Correction with sign bit set; client has already folded rx time
    task t_tc;
        @(posedge CORE_CLK_I);
        TRANSP_CLK_MODE_I <= 1'b1;
        tld <= 1'b1;
        tval <= 80'h0000_8000_0000_0000_1000;
        @(posedge CORE_CLK_I);
        tld <= 1'b0;
        sop(2'h1, 16'hD1);
        t1 = (t0 & ~(80'h1 << 63)) + ({69'h0, TX_LAT_TRIM_I} << 13);
        chk(TX_INS_TS_O, t1 & ~(80'h1 << 63));
        t1 = t0 & ~(80'h1 << 63);
        // One-step frame with insertion off is still returned
        @(posedge CORE_CLK_I);
        TX_ONE_STEP_EN_I <= 1'b0;
        sop(2'h1, 16'hD2);
        done(16'hD1, t1);
        done(16'hD2, t0 & ~(80'h1 << 63));
    endtask
    // Frozen clock enable: a held frame start must not be taken
    task t_ce;
        @(posedge CORE_CLK_I);
        CE_I <= 1'b0;
        TX_SOP_I <= 1'b1;
        TX_FRAME_TS_OPCODE_I <= 2'h1;
        repeat (3) @(posedge CORE_CLK_I);
        TX_SOP_I <= 1'b0;
        #1 chk(TX_INS_VALID_O, 1'b0);
        @(posedge CORE_CLK_I);
        CE_I <= 1'b1;
        pop;
        chk(TX_FIFO_RD_ERR_O, 1'b1);
    endtask
    initial
    begin
        repeat (3) @(posedge CORE_CLK_I);
        SRST_I <= 1'b0;
        t_reg;
        t_rx;
        t_one;
        t_err;
        t_tc;
        t_ce;
        results;
    end
    // Whole run is under a hundred cycles
    initial
    begin
        #200000;
        errors++;
        results;
    end
endmodule
bind pts_ctrl pts_ctrl_assertions i_chk (.*);
